// [pkg/led_cfg_pkg.sv]
// Constants, field layouts and helpers for the LED driver register bank.
// Assumes a single 400-bit word is written or read per access.
package led_cfg_pkg;

  localparam int unsigned WordBits = 400;
  localparam int unsigned LevelBits = 12;
  localparam int unsigned CorrBits = 7;
  localparam int unsigned ChanPerColor = 11;
  localparam int unsigned CmdBits = 12;

  localparam logic [1:0] OffBrightness = 2'h0;
  localparam logic [1:0] OffConfig = 2'h1;
  localparam logic [WordBits-1:0] WordReset = '0;

  localparam logic [CmdBits-1:0] CmdLookahead = 12'hA5D;
  localparam logic [CmdBits-1:0] CmdZap = 12'hA5E;
  localparam logic [CmdBits-1:0] CmdSleep = 12'hA58;
  localparam logic [CmdBits-1:0] CmdWakeup = 12'hA5A;
  localparam logic [CmdBits-1:0] CmdLevelRead = 12'h5AF;
  localparam logic [CmdBits-1:0] CmdStatusRead = 12'h5A3;
  localparam logic [CmdBits-1:0] CmdConfigRead = 12'h5AC;
  localparam logic [CmdBits-1:0] CmdShortCheck = 12'h53A;
  localparam logic [CmdBits-1:0] CmdSelfTest = 12'h535;
  localparam logic [CmdBits-1:0] CmdNegateToggle = 12'h55A;
  localparam logic [CmdBits-1:0] CmdErrorClear = 12'hA53;
  localparam logic [CmdBits-1:0] CmdGlobalReset = 12'hA5C;

  localparam logic [3:0] Counter12 = 4'hC;
  localparam logic [3:0] Counter10 = 4'hA;
  localparam logic [3:0] Counter8 = 4'h8;

  // Layout of current_config_word, most significant field first.
  typedef struct packed {
    logic [3:0] reservedTop;
    logic [CmdBits-1:0] command;
    logic [115:0] reservedMid;
    logic error_mask;
    logic slewTime;
    logic open_detect_threshold;
    logic short_detect_threshold;
    logic adjacent_short_test_current;
    logic adjacent_short_test_time;
    logic [1:0] counter_width_select;
    logic timingRestart;
    logic autoRestart;
    logic blue_correction_range;
    logic green_correction_range;
    logic red_correction_range;
    logic [7:0] blue_group_brightness;
    logic [7:0] green_group_brightness;
    logic [7:0] red_group_brightness;
    logic [3*ChanPerColor*CorrBits-1:0] correction;
  } config_t;

  // One register write request.
  typedef struct packed {
    logic en;
    logic [1:0] offset;
    logic [WordBits-1:0] data;
  } write_req_t;

  function automatic logic isCommand(input logic [CmdBits-1:0] code);
    case (code)
      CmdLookahead, CmdZap, CmdSleep, CmdWakeup, CmdLevelRead, CmdStatusRead,
      CmdConfigRead, CmdShortCheck, CmdSelfTest, CmdNegateToggle,
      CmdErrorClear, CmdGlobalReset: isCommand = 1'b1;
      default: isCommand = 1'b0;
    endcase
  endfunction

  function automatic logic [3:0] counterBits(input logic [1:0] sel);
    case (sel)
      2'h2: counterBits = Counter10;
      2'h3: counterBits = Counter8;
      default: counterBits = Counter12;
    endcase
  endfunction

  // Low bit of the level field for a channel index and colour (0 red, 1 green, 2 blue).
  function automatic int unsigned levelLsb(input int unsigned chan, input int unsigned color);
    levelLsb = (chan * 3 + color) * LevelBits;
  endfunction

endpackage

// [rtl/led_driver_config_regs.sv]
// Register bank holding the per-channel brightness levels and the configuration word.
// Assumes one-word parallel write and read requests synchronous to clk_sys.
// Overview of operation
// - Offset 0h holds a 400-bit brightness word for 33 outputs with its top four bits reserved.
// - Each level field is 12 bits in descending channel order with blue 10 at bits 395 to 384.
// - Within a channel index red is lowest, green middle and blue highest.
// - Every level field is readable, writable and zero after reset.
// - Offset 1h holds a 400-bit readable and writable configuration word.
// - Single-bit settings run from bit 267 down to 255 in the fixed order.
// - Three 8-bit group brightness fields sit below the range bits, red ending at bit 231.
// - Thirty-three 7-bit correction fields run from bit 230 down, blue 10 at 230 to 224.
// - A recognised code in bits 395 to 384 runs a command instead of storing the word.
// - Counter width select gives 12 bits for 0h or 1h, 10 bits for 2h and 8 bits for 3h.
// - Bits 383 to 268 of the configuration word are reserved, writable and zero after reset.
`timescale 1ns/1ps
`default_nettype none

module led_driver_config_regs (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire led_cfg_pkg::write_req_t wrReq,
  input wire logic rdEn,
  input wire logic [1:0] rdOffset,
  output logic [led_cfg_pkg::WordBits-1:0] rdData,
  output logic [led_cfg_pkg::WordBits-1:0] channel_brightness_levels,
  output led_cfg_pkg::config_t current_config_word,
  output logic [3:0] counterBitCount,
  output logic cmdPulse,
  output logic [led_cfg_pkg::CmdBits-1:0] cmdCode
);

  logic [led_cfg_pkg::WordBits-1:0] levels_q;
  led_cfg_pkg::config_t config_q;
  logic [led_cfg_pkg::WordBits-1:0] rdData_q;
  logic [3:0] counterBits_q;
  logic cmdPulse_q;
  logic [led_cfg_pkg::CmdBits-1:0] cmdCode_q;
  logic levelWrite;
  logic configAccess;
  logic commandSeen;
  localparam int unsigned levelLsbB10 = 384;

  assign levelWrite = wrReq.en && (wrReq.offset == led_cfg_pkg::OffBrightness);
  assign configAccess = wrReq.en && (wrReq.offset == led_cfg_pkg::OffConfig);
  assign commandSeen = led_cfg_pkg::isCommand(wrReq.data[395:384]);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      levels_q <= led_cfg_pkg::WordReset;
    end else if (levelWrite) begin
      levels_q <= wrReq.data;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      config_q <= led_cfg_pkg::config_t'(led_cfg_pkg::WordReset);
    end else if (configAccess && !commandSeen) begin
      config_q <= led_cfg_pkg::config_t'(wrReq.data);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmdPulse_q <= 1'b0;
      cmdCode_q <= '0;
    end else begin
      cmdPulse_q <= configAccess && commandSeen;
      if (configAccess && commandSeen) begin
        cmdCode_q <= wrReq.data[395:384];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      counterBits_q <= led_cfg_pkg::Counter12;
    end else begin
      counterBits_q <= led_cfg_pkg::counterBits(config_q.counter_width_select);
    end
  end

  // Reads of any offset other than the two words return zero.
  // reserved bits read back
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdData_q <= '0;
    end else if (rdEn) begin
      if (rdOffset == led_cfg_pkg::OffBrightness) begin
        rdData_q <= levels_q;
      end else if (rdOffset == led_cfg_pkg::OffConfig) begin
        rdData_q <= config_q;
      end else begin
        rdData_q <= '0;
      end
    end
  end

  assign rdData = rdData_q;
  assign channel_brightness_levels = levels_q;
  assign current_config_word = config_q;
  assign counterBitCount = counterBits_q;
  assign cmdPulse = cmdPulse_q;
  assign cmdCode = cmdCode_q;

  sequence cmdWrite;
    configAccess && commandSeen;
  endsequence

  sequence cfgWrite;
    configAccess && !commandSeen;
  endsequence

  a_level_write: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    levelWrite |=> levels_q == $past(wrReq.data))
    else $error("Brightness word not stored.");

  a_blue10_field: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    levelWrite |=> levels_q[levelLsbB10 +: 12] == $past(wrReq.data[395:384]))
    else $error("Blue 10 level field misplaced.");

  a_red0_field: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    levelWrite |=> levels_q[11:0] == $past(wrReq.data[11:0])
      && levels_q[35:24] == $past(wrReq.data[35:24]))
    else $error("Channel 0 level fields misplaced.");

  a_cfg_store: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    cfgWrite |=> config_q == $past(wrReq.data))
    else $error("Configuration word not stored.");

  a_cmd_nostore: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    cmdWrite |=> $stable(config_q) && cmdPulse_q && cmdCode_q == $past(wrReq.data[395:384]))
    else $error("Command word stored or not reported.");

  a_cmd_cause: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    cmdPulse_q |-> $past(configAccess && commandSeen))
    else $error("Command pulse without command write.");

  a_width_eight: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    config_q.counter_width_select == 2'h3 ##1 $stable(config_q) |-> counterBits_q == 4'h8)
    else $error("Select 3h did not give an 8-bit counter.");

  a_width_ten: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    config_q.counter_width_select == 2'h2 ##1 $stable(config_q) |-> counterBits_q == 4'hA)
    else $error("Select 2h did not give a 10-bit counter.");

  a_read_back: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    rdEn && rdOffset == led_cfg_pkg::OffConfig |=> rdData_q == $past(config_q))
    else $error("Configuration read-back differs.");

  a_level_read: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    rdEn && rdOffset == led_cfg_pkg::OffBrightness |=> rdData_q == $past(levels_q))
    else $error("Brightness read-back differs.");

  a_mask_bit: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    cfgWrite |=> config_q.error_mask == $past(wrReq.data[267]))
    else $error("Error mask bit misplaced.");

  a_group_fields: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    cfgWrite |=> config_q.red_group_brightness == $past(wrReq.data[238:231])
      && config_q.blue_group_brightness == $past(wrReq.data[254:247]))
    else $error("Group brightness fields misplaced.");

  a_blue10_corr: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    cfgWrite |=> config_q.correction[230:224] == $past(wrReq.data[230:224]))
    else $error("Blue 10 correction field misplaced.");

  a_reserved_mid: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    cfgWrite |=> config_q.reservedMid == $past(wrReq.data[383:268]))
    else $error("Reserved configuration bits not kept.");

  a_width_twelve: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    config_q.counter_width_select[1] == 1'b0 ##1 $stable(config_q) |-> counterBits_q == 4'hC)
    else $error("Select 0h or 1h did not give a 12-bit counter.");

  // Writes to the unlisted offsets must leave both words alone.
  a_spare_ignored: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    wrReq.en && wrReq.offset[1] |=> $stable(levels_q) && $stable(config_q))
    else $error("Write to an unlisted offset changed a word.");

  a_level_hold: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !levelWrite |=> $stable(levels_q))
    else $error("Brightness word changed without a write.");

  a_code_hold: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !(configAccess && commandSeen) |=> $stable(cmdCode_q))
    else $error("Command code changed without a command.");

endmodule

`default_nettype wire

// [verification/led_host_model.sv]
// Host model that drives the register port of the LED register bank.
// Assumes requests are taken on the rising edge of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module led_host_model (
  input wire logic clk_sys,
  output led_cfg_pkg::write_req_t wrReq,
  output logic rdEn,
  output logic [1:0] rdOffset,
  input wire logic [399:0] rdData
);
  initial begin
    wrReq = '0;
    rdEn = 1'b0;
    rdOffset = 2'h0;
  end
  task automatic put(input logic [1:0] off, input logic [399:0] d);
    @(posedge clk_sys);
    wrReq <= '{1'b1, off, d};
    @(posedge clk_sys);
    wrReq <= '{1'b0, ~off, ~d};
    #1;
  endtask
  task automatic get(input logic [1:0] off, output logic [399:0] d);
    @(posedge clk_sys);
    rdEn <= 1'b1;
    rdOffset <= off;
    @(posedge clk_sys);
    rdEn <= 1'b0;
    rdOffset <= ~off;
    #1;
    d = rdData;
  endtask
endmodule
`default_nettype wire

// [verification/test_led_driver_config_regs.sv]
// Self-checking bench for the LED driver register bank.
// Assumes the host model issues one-cycle write and read pulses.
`timescale 1ns/1ps
`default_nettype none
module test_led_driver_config_regs;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  led_cfg_pkg::write_req_t wrReq;
  logic rdEn;
  logic [1:0] rdOffset;
  logic [399:0] rdData, lv, d, r, q;
  led_cfg_pkg::config_t cfg;
  logic [3:0] cw;
  logic cp;
  logic [11:0] cc;
  logic [31:0] seed = 32'h18049D93;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  logic [11:0] codes [12] = '{12'hA5D, 12'hA5E, 12'hA58, 12'hA5A, 12'h5AF, 12'h5A3,
    12'h5AC, 12'h53A, 12'h535, 12'h55A, 12'hA53, 12'hA5C};
  always #25 clk_sys = ~clk_sys;
  led_host_model i_host (.clk_sys(clk_sys), .wrReq(wrReq), .rdEn(rdEn),
    .rdOffset(rdOffset), .rdData(rdData));
  led_driver_config_regs i_dut (.clk_sys(clk_sys), .resetn(resetn), .wrReq(wrReq),
    .rdEn(rdEn), .rdOffset(rdOffset), .rdData(rdData), .channel_brightness_levels(lv),
    .current_config_word(cfg), .counterBitCount(cw), .cmdPulse(cp), .cmdCode(cc));
  task automatic check(input logic [399:0] seen, input logic [399:0] exp, input string m);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic rnd(output logic [399:0] v);
    for (int i = 0; i < 13; i++) begin
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      v = {v[367:0], seed};
    end
  endtask
  function automatic logic [3:0] widthOf(input logic [1:0] s);
    widthOf = (s == 2'h3) ? 4'h8 : ((s == 2'h2) ? 4'hA : 4'hC);
  endfunction
  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    check(lv, '0, "level reset");
    check(cfg, '0, "config reset");
    check(cw, 4'hC, "width reset");
    for (int i = 0; i < 8; i++) begin
      rnd(d);
      d[395:384] = 12'h0F0 ^ i[11:0];
      r = ~d;
      i_host.put(2'h0, d);
      check(lv, d, "level store");
      check(lv[395:384], d[395:384], "blue10 level");
      check(lv[23:12], d[23:12], "green0 level");
      i_host.put(2'h1, r);
      check(cfg, r, "config store");
      check(cfg.error_mask, r[267], "mask bit");
      check(cfg.red_group_brightness, r[238:231], "red group");
      check(cfg.correction[230:224], r[230:224], "blue10 corr");
      i_host.get(2'h0, q);
      check(q, d, "level read");
      i_host.get(2'h1, q);
      check(q, r, "config read");
    end
    i_host.put(2'h2, d ^ r);
    i_host.put(2'h3, ~r);
    check(lv, d, "reserved write");
    i_host.get(2'h2, q);
    check(q, '0, "reserved read");
    foreach (codes[k]) begin
      d = '0;
      d[395:384] = codes[k];
      i_host.put(2'h1, d);
      check(cp, 1'b1, "cmd pulse");
      check(cc, codes[k], "cmd code");
      check(cfg, r, "cmd kept out");
      @(posedge clk_sys);
      #1;
      check(cp, 1'b0, "pulse width");
    end
    for (int s = 0; s < 4; s++) begin
      d = '0;
      d[261:260] = s[1:0];
      i_host.put(2'h1, d);
      @(posedge clk_sys);
      #1;
      check(cw, widthOf(s[1:0]), "counter width");
    end
    @(posedge clk_sys);
    resetn <= 1'b0;
    #1;
    check(lv, '0, "level rereset");
    check(cfg, '0, "config rereset");
    print_verdict();
  end
endmodule
`default_nettype wire
